// *** hw/smr_top.sv ***
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
module smr_top
  import smr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_clk_en,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // SMBus pins
  input  wire logic        i_smb_scl,
  input  wire logic        i_smb_sda,
  output logic             o_smb_sda_o,
  output logic             o_smb_sda_oe,
  output logic             o_smb_alert_o,
  output logic             o_smb_alert_oe,
  // Received packet
  input  wire logic        i_pkt_valid,
  input  wire smr_rec_t    i_pkt_rec,
  output logic             o_pkt_ready,
  input  wire logic [7:0]  i_pkt_byte,
  output logic             o_pkt_pop,
  output logic             o_pkt_drop,
  // Device status
  input  wire logic        i_link_up,
  input  wire logic        i_keep_link,
  input  wire logic [1:0]  i_pwr_state,
  input  wire logic [7:0]  i_status2,
  input  wire logic        i_cmd_abort,
  input  wire logic        i_nv_reload,
  input  wire logic        i_stat_req,
  // Single fragment payloads
  input  wire smr_aux_t    i_aux,
  output logic      [7:0]  o_aux_cmd
);

  smr_st_t    s_reg;
  smr_st_t    s_next;
  smr_st1_t   st1;
  logic [7:0] b;
  logic [4:0] pi;
  logic [31:0] rd;
  logic       ld;
  logic       clr_st;
  logic       a_ok;
  logic       sc;
  logic       sd;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       pktc;

  // Line events from synchronised pins
  assign sc    = s_reg.s2[1];
  assign sd    = s_reg.s2[0];
  assign rise  = sc & ~s_reg.s3[1];
  assign fall  = ~sc & s_reg.s3[1];
  assign start = sc & s_reg.s3[1] & s_reg.s3[0] & ~sd;
  assign stop  = sc & s_reg.s3[1] & ~s_reg.s3[0] & sd;
  assign pktc  = (s_reg.cmd == CMD_PKT_A) || (s_reg.cmd == CMD_PKT_B);
  assign a_ok  = (i_paddr == A_CTRL) || (i_paddr == A_TMO) ||
                 (i_paddr == A_MACL) || (i_paddr == A_MACH) ||
                 (i_paddr == A_STAT);

  // Status byte 1
  assign st1 = '{port_lsb: s_reg.port[0], aborted: s_reg.abort,
                 link_up: i_link_up, keep_link: i_keep_link,
                 reloaded: s_reg.reload, port_msb: s_reg.port[1],
                 pwr: i_pwr_state};

  // Register read mux
  always_comb begin
    rd = 32'h0000_0000;
    case (i_paddr)
      A_CTRL: rd = {17'h0, s_reg.saddr, 5'h0, s_reg.port, s_reg.nfy_en};
      A_TMO:  rd = {16'h0, s_reg.tmo};
      A_MACL: rd = s_reg.mac[3:0];
      A_MACH: rd = {16'h0, s_reg.mac[5:4]};
      A_STAT: rd = {12'h0, s_reg.pend, s_reg.pnot, s_reg.salert,
                    s_reg.first, i_status2, st1};
      default: rd = 32'h0000_0000;
    endcase
  end

  // Byte to send at current index
  always_comb begin
    pi = s_reg.bi - 5'd2;
    b  = 8'hFF;
    case (s_reg.kind)
      K_PKT: begin
        if (s_reg.bi == 5'd0) begin
          b = {3'b000, s_reg.flen} + 8'd1;
        end else if (s_reg.bi == 5'd1) begin
          b = s_reg.first ? OP_FIRST : OP_MID;
        end else if (s_reg.bi <= s_reg.flen + 5'd1) begin
          b = i_pkt_byte;
        end
      end
      K_LAST: begin
        if (s_reg.bi == 5'd0) begin
          b = CNT_LAST;
        end else if (s_reg.bi == 5'd1) begin
          b = OP_LAST;
        end else if (s_reg.bi <= BI_LAST) begin
          b = s_reg.rec[{pi[3:0], 3'b000} +: 8];
        end
      end
      K_STAT: begin
        if (s_reg.bi == 5'd0) begin
          b = CNT_STAT;
        end else if (s_reg.bi == 5'd1) begin
          b = OP_STAT;
        end else if (s_reg.bi == 5'd2) begin
          b = st1;
        end else if (s_reg.bi == 5'd3) begin
          b = i_status2;
        end
      end
      K_AUX: begin
        if (s_reg.bi == 5'd0) begin
          b = {3'b000, i_aux.len} + 8'd1;
        end else if (s_reg.bi == 5'd1) begin
          b = s_reg.cmd;
        end else if (pi < i_aux.len) begin
          b = i_aux.data[pi[3:0]];
        end
      end
      K_MAC: begin
        if (s_reg.bi == 5'd0) begin
          b = CNT_MAC;
        end else if (s_reg.bi == 5'd1) begin
          b = CMD_MAC;
        end else if (pi < 5'd6) begin
          b = s_reg.mac[3'd5 - pi[2:0]];
        end
      end
      default: b = 8'hFF;
    endcase
  end

  // Next state
  always_comb begin
    s_next      = s_reg;
    ld          = 1'b0;
    clr_st      = 1'b0;
    s_next.pop  = 1'b0;
    s_next.drop = 1'b0;
    s_next.s1   = {i_smb_scl, i_smb_sda};
    s_next.s2   = s_reg.s1;
    s_next.s3   = s_reg.s2;
    // Bus engine
    if (start) begin
      s_next.sm     = SM_ADDR;
      s_next.cnt    = 4'd0;
      s_next.sda_oe = 1'b0;
      s_next.lp     = 1'b0;
    end else if (stop) begin
      s_next.sm     = SM_IDLE;
      s_next.sda_oe = 1'b0;
      s_next.lp     = 1'b0;
    end else begin
      case (s_reg.sm)
        SM_ADDR, SM_CMD: begin
          if (rise) begin
            s_next.sh  = {s_reg.sh[6:0], sd};
            s_next.cnt = s_reg.cnt + 4'd1;
          end else if (fall && s_reg.cnt == 4'd8) begin
            if (s_reg.sm == SM_CMD) begin
              s_next.cmd    = s_reg.sh;
              s_next.incmd  = 1'b1;
              s_next.sda_oe = 1'b1;
              s_next.sm     = SM_ACK;
            end else if (s_reg.sh[7:1] == s_reg.saddr) begin
              s_next.rw     = s_reg.sh[0];
              s_next.incmd  = 1'b0;
              s_next.sda_oe = 1'b1;
              s_next.sm     = SM_ACK;
              s_next.tmr_on = 1'b0;
            end else begin
              s_next.sm = SM_IDLE;
            end
          end
        end
        SM_ACK: begin
          if (fall) begin
            s_next.sda_oe = 1'b0;
            s_next.cnt    = 4'd0;
            if (s_reg.incmd) begin
              s_next.sm = SM_IDLE;
            end else if (!s_reg.rw) begin
              s_next.sm = SM_CMD;
            end else begin
              s_next.sm   = SM_TX;
              s_next.lp   = 1'b1;
              s_next.bi   = 5'd0;
              s_next.flen = (s_reg.rem > FRAG_MAX) ? FRAG_MAX[4:0] : s_reg.rem[4:0];
              if (pktc && s_reg.pend) begin
                s_next.kind = (s_reg.rem == 14'd0) ? K_LAST : K_PKT;
              end else if (pktc || s_reg.cmd == CMD_STAT) begin
                s_next.kind = K_STAT;
              end else if (s_reg.cmd == CMD_RXEN || s_reg.cmd == CMD_MGMT ||
                           s_reg.cmd == CMD_FILT) begin
                s_next.kind = K_AUX;
              end else if (s_reg.cmd == CMD_MAC) begin
                s_next.kind = K_MAC;
              end else begin
                s_next.kind = K_STAT;
              end
            end
          end
        end
        SM_TX: begin
          if (s_reg.lp) begin
            ld            = 1'b1;
            s_next.lp     = 1'b0;
            s_next.txb    = b;
            s_next.sda_oe = ~b[7];
            s_next.cnt    = 4'd0;
            if (s_reg.bi != 5'h1F) begin
              s_next.bi = s_reg.bi + 5'd1;
            end
          end else if (rise) begin
            s_next.cnt = s_reg.cnt + 4'd1;
          end else if (fall) begin
            if (s_reg.cnt == 4'd8) begin
              s_next.sda_oe = 1'b0;
              s_next.sm     = SM_RACK;
            end else begin
              s_next.txb    = {s_reg.txb[6:0], 1'b0};
              s_next.sda_oe = ~s_reg.txb[6];
            end
          end
        end
        SM_RACK: begin
          if (rise) begin
            s_next.ack = ~sd;
          end else if (fall) begin
            s_next.sm = s_reg.ack ? SM_TX : SM_IDLE;
            s_next.lp = s_reg.ack;
          end
        end
        default: s_next.sm = SM_IDLE;
      endcase
    end
    // Side effects of a loaded byte
    if (ld) begin
      case (s_reg.kind)
        K_PKT: begin
          if (s_reg.bi == 5'd1) begin
            s_next.first = 1'b0;
            s_next.pnot  = 1'b0;
          end else if (s_reg.pend && s_reg.bi >= 5'd2 &&
                       s_reg.bi <= s_reg.flen + 5'd1) begin
            s_next.pop = 1'b1;
            s_next.rem = s_reg.rem - 14'd1;
          end
        end
        K_LAST: begin
          if (s_reg.bi == BI_LAST) begin
            s_next.pend = 1'b0;
          end
        end
        K_STAT: begin
          if (s_reg.bi == 5'd2) begin
            clr_st = 1'b1;
          end
        end
        default: clr_st = 1'b0;
      endcase
    end
    // Notification timeout
    if (s_reg.tmr_on) begin
      if (s_reg.tdiv == TICK_CYC - 8'd1) begin
        s_next.tdiv = 8'd0;
        s_next.tcnt = s_reg.tcnt + 16'd1;
      end else begin
        s_next.tdiv = s_reg.tdiv + 8'd1;
      end
      if (s_reg.tmo != 16'd0 && s_reg.tcnt >= s_reg.tmo) begin
        s_next.tmr_on = 1'b0;
        s_next.pend   = 1'b0;
        s_next.pnot   = 1'b0;
        s_next.drop   = 1'b1;
      end
    end
    // Packet intake
    if (i_pkt_valid && !s_reg.pend) begin
      s_next.pend        = 1'b1;
      s_next.first       = 1'b1;
      s_next.pnot        = 1'b1;
      s_next.tmr_on      = 1'b1;
      s_next.tdiv        = 8'd0;
      s_next.tcnt        = 16'd0;
      s_next.rem         = i_pkt_rec.len;
      s_next.rec         = i_pkt_rec;
      s_next.rec.rsv_a   = '0;
      s_next.rec.rsv_b   = '0;
      s_next.rec.rsv_c   = '0;
      s_next.rec.rxst.rsv_a = '0;
      s_next.rec.rxst.rsv_b = '0;
      s_next.rec.rxst.rsv_c = '0;
      s_next.rec.err.rsv    = '0;
      s_next.rec.ptype.rsv  = '0;
      s_next.rec.mstat.rsv_a = '0;
      s_next.rec.mstat.rsv_b = '0;
    end
    // Status flags, set beats clear
    s_next.prev = {st1.port_lsb, st1.link_up, st1.keep_link, st1.port_msb, 1'b0};
    if (clr_st) begin
      s_next.abort  = 1'b0;
      s_next.reload = 1'b0;
      s_next.salert = 1'b0;
    end
    if (s_reg.nfy_en && (s_reg.prev != s_next.prev ||
        i_cmd_abort || i_nv_reload)) begin
      s_next.salert = 1'b1;
    end
    if (i_cmd_abort) begin
      s_next.abort = 1'b1;
    end
    if (i_nv_reload) begin
      s_next.reload = 1'b1;
    end
    if (i_stat_req) begin
      s_next.salert = 1'b1;
    end
    // APB slave
    if (i_psel && !i_penable) begin
      s_next.prdata = rd;
    end
    if (i_psel && i_penable && i_pwrite && a_ok) begin
      case (i_paddr)
        A_CTRL: begin
          s_next.nfy_en = i_pwdata[0];
          s_next.port   = i_pwdata[2:1];
          s_next.saddr  = i_pwdata[14:8];
        end
        A_TMO:  s_next.tmo = i_pwdata[15:0];
        A_MACL: s_next.mac[3:0] = i_pwdata;
        A_MACH: s_next.mac[5:4] = i_pwdata[15:0];
        default: s_next.nfy_en = s_reg.nfy_en;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_reg <= ST_RST;
    end else if (i_clk_en) begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign o_prdata       = s_reg.prdata;
  assign o_pready       = i_clk_en;
  assign o_pslverr      = i_psel & i_penable & ~a_ok;
  assign o_smb_sda_o    = 1'b0;
  assign o_smb_sda_oe   = s_reg.sda_oe;
  assign o_smb_alert_o  = 1'b0;
  assign o_smb_alert_oe = s_reg.salert | s_reg.pnot;
  assign o_pkt_ready    = ~s_reg.pend & i_clk_en;
  assign o_pkt_pop      = s_reg.pop;
  assign o_pkt_drop     = s_reg.drop;
  assign o_aux_cmd      = s_reg.cmd;

  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_notify;
    i_clk_en && i_pkt_valid && o_pkt_ready |=> o_smb_alert_oe;
  endproperty
  a_notify: assert property (p_notify) else $error("no alert on packet");
  property p_drop;
    $rose(o_pkt_drop) |-> !s_reg.pend && $past(s_reg.pend);
  endproperty
  a_drop: assert property (p_drop) else $error("drop without packet");
  property p_empty;
    $rose(s_reg.lp) && s_reg.bi == 5'd0 && pktc && !$past(s_reg.pend)
      |-> s_reg.kind == K_STAT;
  endproperty
  a_empty: assert property (p_empty) else $error("empty read not status");
  property p_stat;
    $rose(s_reg.lp) && s_reg.cmd == CMD_STAT |-> s_reg.kind == K_STAT;
  endproperty
  a_stat: assert property (p_stat) else $error("status command misrouted");
  property p_stat_cnt;
    i_clk_en && ld && s_reg.kind == K_STAT && s_reg.bi == 5'd0 |=> s_reg.txb == 8'h03;
  endproperty
  a_stat_cnt: assert property (p_stat_cnt) else $error("bad status count");
  property p_last;
    i_clk_en && ld && s_reg.kind == K_LAST && s_reg.bi == 5'd1 |=> s_reg.txb == 8'h50;
  endproperty
  a_last: assert property (p_last) else $error("bad last op-code");
  property p_frag;
    i_clk_en && ld && s_reg.kind == K_PKT && s_reg.bi == 5'd1
      |=> s_reg.txb[7:6] == ($past(s_reg.first) ? 2'b10 : 2'b00);
  endproperty
  a_frag: assert property (p_frag) else $error("bad fragment flags");
  property p_mac;
    i_clk_en && ld && s_reg.kind == K_MAC && s_reg.bi == 5'd1 |=> s_reg.txb == 8'hD4;
  endproperty
  a_mac: assert property (p_mac) else $error("bad address op-code");
  property p_abort;
    i_clk_en && i_cmd_abort |=> s_reg.abort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort event lost");
  property p_req;
    i_clk_en && i_stat_req |=> o_smb_alert_oe;
  endproperty
  a_req: assert property (p_req) else $error("no alert on request");

  c_status: cover property (i_clk_en && ld && s_reg.kind == K_STAT);
  c_last: cover property (i_clk_en && ld && s_reg.kind == K_LAST && s_reg.bi == 5'd17);
  c_drop: cover property ($rose(o_pkt_drop));

endmodule : smr_top

// *** hw/smr_pkg.sv ***
package smr_pkg;
// Function
// - Every read answers count, op-code, then payload
// - Packet fragments use op-codes 0x90, 0x10, 0x50
// - Packet spans data then status fragment
// - Queued packet raises the bus alert
// - Unanswered notification drops packet after timeout
// - Nothing pending: packet command returns status
// - Status command always returns status reply
// - Config reads echo command as op-code
// - Address read echoes its command op-code
// - Status fragment: count 17, 16 bytes ascending
// - Record bits 13:0 hold frame length
// - Record fields placed; reserved bits zero
// - Receive flag bits at fixed positions
// - Error flag bits at fixed positions
// - Packet type bits 12 and 11 placed
// - Filter, IP match bits placed
// - Port filter match bits placed
// - Unicast and VLAN match bits placed
// - ARP, broadcast, port, ethertype bits placed
// - Alert on status request or change
// - Status reply: count 3, 0xDD, two bytes
// - Byte 1 bit 7 is port low bit
// - Abort flag sticky until status read
// - Link, keep-link, reload, power in byte 1

  // Commands and op-codes
  localparam logic [7:0]  CMD_PKT_A = 8'hC0;
  localparam logic [7:0]  CMD_PKT_B = 8'hD0;
  localparam logic [7:0]  CMD_STAT  = 8'hDE;
  localparam logic [7:0]  CMD_RXEN  = 8'hDA;
  localparam logic [7:0]  CMD_MGMT  = 8'hD1;
  localparam logic [7:0]  CMD_FILT  = 8'hCD;
  localparam logic [7:0]  CMD_MAC   = 8'hD4;
  localparam logic [7:0]  OP_FIRST  = 8'h90;
  localparam logic [7:0]  OP_MID    = 8'h10;
  localparam logic [7:0]  OP_LAST   = 8'h50;
  localparam logic [7:0]  OP_STAT   = 8'hDD;
  localparam logic [7:0]  CNT_LAST  = 8'h11;
  localparam logic [7:0]  CNT_STAT  = 8'h03;
  localparam logic [7:0]  CNT_MAC   = 8'h07;
  localparam logic [4:0]  BI_LAST   = 5'h11;
  localparam logic [13:0] FRAG_MAX  = 14'h001E;
  // Register offsets
  localparam logic [7:0]  A_CTRL = 8'h00;
  localparam logic [7:0]  A_TMO  = 8'h04;
  localparam logic [7:0]  A_MACL = 8'h08;
  localparam logic [7:0]  A_MACH = 8'h0C;
  localparam logic [7:0]  A_STAT = 8'h10;
  // Reset values and timing
  localparam logic [6:0]  SADDR_RST = 7'h49;
  localparam logic [15:0] TMO_RST   = 16'h03E8;
  localparam int          CLK_NS    = 5;
  localparam int          TICK_NS   = 1000;
  localparam logic [7:0]  TICK_CYC  = 8'(TICK_NS / CLK_NS);

  typedef enum logic [2:0] {
    SM_IDLE = 3'b000, SM_ADDR = 3'b001, SM_ACK = 3'b011,
    SM_TX = 3'b111, SM_RACK = 3'b110, SM_CMD = 3'b010
  } smr_sm_t;
  typedef enum logic [2:0] {
    K_STAT = 3'b000, K_PKT = 3'b001, K_LAST = 3'b011,
    K_AUX = 3'b010, K_MAC = 3'b110
  } smr_kind_t;

  typedef struct packed {
    logic [1:0] src_port;
    logic       vlan_stripped;
    logic       extra_vlan;
    logic [5:0] rsv_a;
    logic       crc_stripped;
    logic [4:0] rsv_b;
    logic       udp_sum_valid;
    logic [1:0] rsv_c;
    logic       ipv4_sum_done;
    logic       l4_sum_done;
    logic       udp_sum_done;
  } smr_rxst_t;
  typedef struct packed {
    logic       rx_data_error;
    logic       ipv4_sum_error;
    logic       l4_sum_error;
    logic [1:0] rsv;
  } smr_err_t;
  typedef struct packed {
    logic        vlan_pkt;
    logic        ethertype_queue_filter;
    logic [10:0] rsv;
  } smr_ptype_t;
  typedef struct packed {
    logic [7:0] dec_hit;
    logic       ip_v6;
    logic       ip_match;
    logic [1:0] ip_idx;
    logic       flex_match;
    logic [2:0] rsv_a;
    logic       l4_match;
    logic [6:0] l4_idx;
    logic       uc_match;
    logic [2:0] uc_idx;
    logic       vlan_match;
    logic [2:0] vlan_idx;
    logic [2:0] rsv_b;
    logic       arp;
    logic       nbr;
    logic       bcast;
    logic       remote_mgmt_port_298;
    logic       remote_mgmt_port_26f;
    logic       mgmt_ethertype_filter;
    logic [1:0] mgmt_ethertype_idx;
  } smr_match_t;
  typedef struct packed {
    smr_match_t  mstat;
    logic [3:0]  rsv_a;
    smr_ptype_t  ptype;
    logic [3:0]  rsv_b;
    logic [15:0] vlan_tag;
    smr_err_t    err;
    logic [6:0]  rsv_c;
    smr_rxst_t   rxst;
    logic [13:0] len;
  } smr_rec_t;
  typedef struct packed {
    logic       port_lsb;
    logic       aborted;
    logic       link_up;
    logic       keep_link;
    logic       reloaded;
    logic       port_msb;
    logic [1:0] pwr;
  } smr_st1_t;
  typedef struct packed {
    logic [4:0]      len;
    logic [15:0][7:0] data;
  } smr_aux_t;
  typedef struct packed {
    logic [1:0]      s1;
    logic [1:0]      s2;
    logic [1:0]      s3;
    smr_sm_t         sm;
    smr_kind_t       kind;
    logic [7:0]      sh;
    logic [7:0]      txb;
    logic [3:0]      cnt;
    logic            rw;
    logic            incmd;
    logic            ack;
    logic            lp;
    logic            sda_oe;
    logic [7:0]      cmd;
    logic [4:0]      bi;
    logic [4:0]      flen;
    logic            pend;
    logic            first;
    logic            pnot;
    logic [13:0]     rem;
    smr_rec_t        rec;
    logic            pop;
    logic            drop;
    logic            tmr_on;
    logic [7:0]      tdiv;
    logic [15:0]     tcnt;
    logic            abort;
    logic            reload;
    logic            salert;
    logic [4:0]      prev;
    logic            nfy_en;
    logic [1:0]      port;
    logic [6:0]      saddr;
    logic [15:0]     tmo;
    logic [5:0][7:0] mac;
    logic [31:0]     prdata;
  } smr_st_t;

  localparam smr_st_t ST_RST = '{s1: 2'b11, s2: 2'b11, s3: 2'b11,
    sm: SM_IDLE, kind: K_STAT, saddr: SADDR_RST, tmo: TMO_RST,
    default: '0};
endpackage : smr_pkg

// *** bench/smr_smb_master.sv ***
`timescale 1ns/100ps
module smr_smb_master (
  // Clock and wire level
  input  wire logic i_clk,
  input  wire logic i_sda,
  // Driven pins
  output logic      o_scl,
  output logic      o_sda_low
);
  logic [7:0] rb [0:40];
  logic       acked;
  // Idle bus, clock high and data released
  initial begin
    o_scl = 1'h1;
    o_sda_low = 1'h0;
  end
  // Half period of the bus clock
  task automatic hp;
    repeat (16) @(posedge i_clk);
  endtask : hp
  // One bit, level taken at end of high phase
  task automatic bit_io(input logic b, output logic r);
    o_sda_low <= !b;
    hp();
    o_scl <= 1'h1;
    hp();
    r = i_sda;
    o_scl <= 1'h0;
  endtask : bit_io
  task automatic byte_io(input logic [7:0] d, input logic b9, output logic [7:0] q,
                         output logic r);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(b9, r);
  endtask : byte_io
  task automatic start;
    o_sda_low <= 1'h0;
    hp();
    o_scl <= 1'h1;
    hp();
    o_sda_low <= 1'h1;
    hp();
    o_scl <= 1'h0;
  endtask : start
  // Block read; acks all but the last byte
  task automatic rd(input logic [7:0] cmd, input int n);
    logic [7:0] x;
    logic       a0, a1, a2, r;
    start();
    byte_io(8'h92, 1'h1, x, a0);
    byte_io(cmd, 1'h1, x, a1);
    start();
    byte_io(8'h93, 1'h1, x, a2);
    for (int k = 0; k < n; k++)
      byte_io(8'hFF, k == n - 1, rb[k], r);
    o_sda_low <= 1'h1;
    hp();
    o_scl <= 1'h1;
    hp();
    o_sda_low <= 1'h0;
    hp();
    acked = !a0 && !a1 && !a2;
  endtask : rd
endmodule : smr_smb_master

// *** bench/tb.sv ***
`timescale 1ns/100ps
module tb;
  import smr_pkg::*;
  localparam logic [127:0] RAW = 128'h80000000_00000000_BEEF0000_0008001F;
  logic        clk, rstn, psel, pen, pwrite, stat_req, abort, pvalid, link;
  logic        pready, pslverr, alert_oe, pkt_ready, pop, drop, e, scl, sda_low, sda_oe;
  logic [7:0]  paddr, idx, aux_cmd;
  logic [31:0] pwdata, prdata;
  logic [1:0]  pwr_st;
  smr_rec_t    rec;
  smr_aux_t    aux;
  int          fails, checks;
  wire         sda = !(sda_low | sda_oe);
  smr_top u_smr_top (.i_ref_clk(clk), .i_resetn(rstn), .i_clk_en(1'h1), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_smb_scl(scl),
    .i_smb_sda(sda), .o_smb_sda_o(), .o_smb_sda_oe(sda_oe), .o_smb_alert_o(),
    .o_smb_alert_oe(alert_oe), .i_pkt_valid(pvalid), .i_pkt_rec(rec),
    .o_pkt_ready(pkt_ready), .i_pkt_byte(8'hA0 + idx), .o_pkt_pop(pop), .o_pkt_drop(drop),
    .i_link_up(link), .i_keep_link(1'h0), .i_pwr_state(pwr_st), .i_status2(8'h5A),
    .i_cmd_abort(abort), .i_nv_reload(1'h0), .i_stat_req(stat_req), .i_aux(aux),
    .o_aux_cmd(aux_cmd));
  smr_smb_master u_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  // Clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = !clk;
  end
  // Packet data advances on each pop
  always @(posedge clk) begin
    if (pop)
      idx <= idx + 8'h01;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic xe);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    chk("pready", 1, pready);
    if (pready !== 1'h1)
      wrap_up();
    if (!w)
      chk("prdata", x, prdata);
    chk("pslverr", xe, pslverr);
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb
  task automatic frag(input logic [7:0] cmd, input int n, input logic [7:0] op);
    u_mst.rd(cmd, n);
    chk("ack", 1, u_mst.acked);
    chk("count", n - 1, u_mst.rb[0]);
    chk("opcode", op, u_mst.rb[1]);
  endtask : frag
  task automatic queue;
    @(posedge clk);
    rec <= smr_rec_t'(RAW | 128'h10_0000_0000);
    pvalid <= 1'h1;
    @(posedge clk);
    pvalid <= 1'h0;
    repeat (2) @(posedge clk);
    chk("alert", 1, alert_oe);
    chk("pkt_ready", 0, pkt_ready);
  endtask : queue
  task automatic t_status;
    apb(1'h1, A_CTRL, 32'h4902, 0, 1'h0);
    link <= 1'h1;
    pwr_st <= 2'h2;
    abort <= 1'h1;
    stat_req <= 1'h1;
    @(posedge clk);
    abort <= 1'h0;
    stat_req <= 1'h0;
    repeat (2) @(posedge clk);
    chk("alert", 1, alert_oe);
    frag(CMD_STAT, 4, OP_STAT);
    chk("st1", 8'hE2, u_mst.rb[2]);
    chk("st2", 8'h5A, u_mst.rb[3]);
    chk("alert", 0, alert_oe);
    frag(CMD_PKT_B, 4, OP_STAT);
    chk("st1", 8'hA2, u_mst.rb[2]);
    apb(1'h1, A_CTRL, 32'h4903, 0, 1'h0);
    link <= 1'h0;
    repeat (3) @(posedge clk);
    chk("alert", 1, alert_oe);
    frag(CMD_STAT, 4, OP_STAT);
    chk("st1", 8'h82, u_mst.rb[2]);
    chk("alert", 0, alert_oe);
  endtask : t_status
  task automatic t_packet;
    queue();
    frag(CMD_PKT_A, 32, OP_FIRST);
    for (int k = 0; k < 30; k++)
      chk("data", 8'hA0 + k, u_mst.rb[k + 2]);
    frag(CMD_PKT_B, 3, OP_MID);
    chk("data", 8'hBE, u_mst.rb[2]);
    frag(CMD_PKT_A, 18, OP_LAST);
    for (int k = 0; k < 16; k++)
      chk("record", RAW[8 * k +: 8], u_mst.rb[k + 2]);
    repeat (4) @(posedge clk);
    chk("pkt_ready", 1, pkt_ready);
  endtask : t_packet
  task automatic t_single;
    logic [7:0] c [3] = '{CMD_RXEN, CMD_MGMT, CMD_FILT};
    for (int k = 0; k < 3; k++) begin
      frag(c[k], 4, c[k]);
      chk("aux", 16'h2211, {u_mst.rb[3], u_mst.rb[2]});
      chk("aux_cmd", c[k], aux_cmd);
    end
    apb(1'h1, A_MACL, 32'h44332211, 0, 1'h0);
    apb(1'h1, A_MACH, 32'h6655, 0, 1'h0);
    apb(1'h0, A_MACL, 0, 32'h44332211, 1'h0);
    frag(CMD_MAC, 8, CMD_MAC);
    for (int k = 0; k < 6; k++)
      chk("mac", 8'h66 - 8'h11 * k, u_mst.rb[k + 2]);
  endtask : t_single
  task automatic t_drop;
    int n;
    n = 0;
    apb(1'h1, A_TMO, 32'h1, 0, 1'h0);
    queue();
    while (drop !== 1'h1 && n < 1000) begin
      n++;
      @(posedge clk);
    end
    chk("drop time", 1, n >= 150 && n < 450);
    if (drop !== 1'h1)
      wrap_up();
    repeat (2) @(posedge clk);
    chk("alert", 0, alert_oe);
    chk("pkt_ready", 1, pkt_ready);
  endtask : t_drop
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  // Watchdog
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {rstn, psel, pen, pwrite, stat_req, abort, pvalid, link} = '0;
    {paddr, idx, pwdata, pwr_st, rec, fails, checks} = '0;
    aux = '0;
    aux.len = 5'h02;
    aux.data[0] = 8'h11;
    aux.data[1] = 8'h22;
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    repeat (3) @(posedge clk);
    apb(1'h0, A_CTRL, 0, 32'h4900, 1'h0);
    apb(1'h0, A_TMO, 0, 32'h3E8, 1'h0);
    apb(1'h0, 8'h20, 0, 0, 1'h1);
    t_status();
    t_packet();
    t_single();
    t_drop();
    wrap_up();
  end
endmodule : tb
